// ### msd_checker.sv
// Purpose: timing and mapping checks on the decoder ports
// Assumes: mode bits reach the decode two edges late
// Notes: mode history reset like the synchroniser
`timescale 1ns/1ps
`default_nettype none
module msd_checker (
  input wire logic clk_sys, input wire logic reset, input wire logic block_zero_placement,
  input wire logic data_space_sram_enable, input wire logic boot_rom_enable, input wire logic req_valid,
  input wire logic req_prog, input wire logic req_write, input wire logic [15:0] req_addr,
  input wire logic rd_valid, input wire logic [2:0] tgt_sel, input wire logic ext_write,
  input wire logic reserved_hit, input wire logic password_hit
);
  logic [2:0] m1, m2, m3;
  wire [2:0] on = m2 & m3;
  wire [2:0] off = ~(m2 | m3);
  wire dq = req_valid && !req_prog;
  wire pq = req_valid && req_prog;
  // Mode history; only judge when steady across the sync delay
  always @(posedge clk_sys) begin
    m1 <= reset ? 3'h0 : {boot_rom_enable, data_space_sram_enable, block_zero_placement};
    m2 <= reset ? 3'h0 : m1;
    m3 <= reset ? 3'h0 : m2;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_read_lat: assert property (req_valid && !req_write |-> ##2 rd_valid) else $error("late read");
  a_blk1_alias: assert property (dq && (req_addr[15:8] == 8'h03 || req_addr[15:8] == 8'h04)
    |=> tgt_sel == 3'h3) else $error("block one miss");
  a_blk0_prog: assert property (pq && req_addr[15:9] == 7'h7f && on[0] |=> tgt_sel == 3'h3) else $error("blk0 prog");
  a_blk0_data: assert property (dq && (req_addr[15:8] == 8'h01 || req_addr[15:8] == 8'h02) && off[0]
    |=> tgt_sel == 3'h3) else $error("blk0 data");
  a_blk0_moved: assert property (dq && req_addr[15:8] == 8'h02 && on[0] |=> reserved_hit) else $error("blk0 gone");
  a_boot_take: assert property (pq && req_addr[15:8] == 8'h00 && on[2] |=> tgt_sel == 3'h1) else $error("boot");
  a_pwd_flag: assert property (pq && req_addr[15:2] == 14'h0010 |=> password_hit) else $error("pwd");
  a_devid_ro: assert property (dq && req_addr == 16'h701c |=> tgt_sel == 3'h4 && !ext_write) else $error("id");
  a_sa_off: assert property (dq && req_addr[15:9] == 7'h04 && off[1] |=> reserved_hit) else $error("sa off");
endmodule // msd_checker
bind msd_decode msd_checker i_chk (.clk_sys(clk_sys), .reset(reset), .block_zero_placement(block_zero_placement),
  .data_space_sram_enable(data_space_sram_enable), .boot_rom_enable(boot_rom_enable), .req_valid(req_valid),
  .req_prog(req_prog), .req_write(req_write), .req_addr(req_addr), .rd_valid(rd_valid), .tgt_sel(tgt_sel),
  .ext_write(ext_write), .reserved_hit(reserved_hit), .password_hit(password_hit));
`default_nettype wire

// ### msd_cpu_model.sv
// Purpose: core bus model issuing single-word requests
// Assumes: one request per call, two cycles apart
// Notes: released bus shows inverted values so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module msd_cpu_model (
  input wire logic clk_sys,
  output logic req_valid,
  output logic req_prog,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata
);
  initial begin
    {req_valid, req_prog, req_write, req_addr, req_wdata} = 35'h0;
  end
  // Held a full cycle, then released to the inverse
  task bus(input logic p, input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 {req_valid, req_prog, req_write, req_addr, req_wdata} = {1'b1, p, w, a, d};
    @(posedge clk_sys);
    #1 {req_valid, req_prog, req_write, req_addr, req_wdata} = {1'b0, ~p, ~w, ~a, ~d};
  endtask
endmodule // msd_cpu_model
`default_nettype wire

// ### msd_decode.v
// Purpose: program and data memory space decoder with on-chip RAM
// Assumes: one request per cycle from the core; req_prog selects program or data space
// Notes: read data valid two cycles after the request, marked by rd_valid
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.vh"
module msd_decode #(
  parameter [15:0] DEVICE_ID = 16'h5a01, // Arbitrary neutral value
  parameter [15:0] BOOT_WORD = 16'h0000
) (
  input wire clk_sys,
  input wire reset,
  input wire block_zero_placement,
  input wire data_space_sram_enable,
  input wire program_space_sram_enable,
  input wire boot_rom_enable,
  input wire req_valid,
  input wire req_prog,
  input wire req_write,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  output reg rd_valid,
  output reg [15:0] rd_data,
  output reg [2:0] tgt_sel,
  output reg [15:0] ext_addr,
  output reg ext_write,
  output reg [15:0] ext_wdata,
  output reg reserved_hit,
  output reg password_hit
);
  // Mode bits are loose pins from another domain: two flops each
  reg [3:0] mode_meta_reg;
  reg [3:0] mode_reg;
  always @(posedge clk_sys) begin
    if (reset) begin
      mode_meta_reg <= 4'h0;
      mode_reg <= 4'h0;
    end else begin
      mode_meta_reg <= {boot_rom_enable, program_space_sram_enable, data_space_sram_enable, block_zero_placement};
      mode_reg <= mode_meta_reg;
    end
  end
  // Synchronised mode bits, named by what they steer
  wire bzp_sync = mode_reg[0];
  wire dse_sync = mode_reg[1];
  wire pse_sync = mode_reg[2];
  wire boot_sync = mode_reg[3];

  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // RAM row from a region base and the low address bits
  function [10:0] ram_row;
    input [10:0] base;
    input [8:0] offs;
    begin
      ram_row = base + {2'b00, offs};
    end
  endfunction

  // Program space window hits, from the live request
  wire hit_boot = boot_sync && (req_addr <= `MSD_BOOT_LAST);
  wire hit_store = (req_addr <= `MSD_PSTORE_LAST);
  wire hit_sa_prog = pse_sync && in_rng(req_addr, `MSD_SA_PROG_BASE, `MSD_SA_PROG_LAST);
  wire hit_blk0_prog = bzp_sync && (req_addr >= `MSD_BLK0_PROG_ALIAS);
  wire hit_pwd = in_rng(req_addr, `MSD_PWD_FIRST, `MSD_PWD_LAST);

  // Data space window hits; block zero only while placed in data
  wire hit_blk2 = in_rng(req_addr, `MSD_B2_DATA_BASE, `MSD_B2_DATA_LAST);
  wire hit_blk0_data = !bzp_sync && in_rng(req_addr, `MSD_BLK0_DATA_ALIAS, `MSD_BLK0_DATA_LAST);
  wire hit_blk1 = in_rng(req_addr, `MSD_BLK1_DATA_BASE, `MSD_BLK1_DATA_LAST);
  wire hit_sa_data = dse_sync && in_rng(req_addr, `MSD_SA_DATA_BASE, `MSD_SA_DATA_LAST);
  wire hit_devid = (req_addr == `MSD_DEVID_ADDR);
  wire hit_periph = in_rng(req_addr, `MSD_PERIPH_BASE, `MSD_PERIPH_LAST);

  // Program side: boot ROM shadows the store, then SA RAM, then block zero
  reg [2:0] prog_tgt;
  reg [10:0] prog_idx;
  reg prog_rsvd;
  always @* begin
    prog_tgt = `MSD_TGT_NONE;
    prog_idx = 11'h000;
    prog_rsvd = 1'b1;
    if (hit_boot) begin
      prog_tgt = `MSD_TGT_BOOT;
      prog_rsvd = 1'b0;
    end else if (hit_store) begin
      prog_tgt = `MSD_TGT_PSTORE;
      prog_rsvd = 1'b0;
    end else if (hit_sa_prog) begin
      prog_tgt = `MSD_TGT_RAM;
      prog_idx = ram_row(`MSD_RAM_SA_BASE, req_addr[8:0]);
      prog_rsvd = 1'b0;
    end else if (hit_blk0_prog) begin
      // Both 256-word halves fold onto one set of rows
      prog_tgt = `MSD_TGT_RAM;
      prog_idx = ram_row(`MSD_RAM_BLK0_BASE, {1'b0, req_addr[7:0]});
      prog_rsvd = 1'b0;
    end
  end

  // Data side: aliases drop the high bits so both halves share rows
  reg [2:0] data_tgt;
  reg [10:0] data_idx;
  reg data_rsvd;
  always @* begin
    data_tgt = `MSD_TGT_NONE;
    data_idx = 11'h000;
    data_rsvd = 1'b1;
    if (hit_blk2) begin
      data_tgt = `MSD_TGT_RAM;
      data_idx = ram_row(`MSD_RAM_B2_BASE, {4'h0, req_addr[4:0]});
      data_rsvd = 1'b0;
    end else if (hit_blk0_data) begin
      data_tgt = `MSD_TGT_RAM;
      data_idx = ram_row(`MSD_RAM_BLK0_BASE, {1'b0, req_addr[7:0]});
      data_rsvd = 1'b0;
    end else if (hit_blk1) begin
      data_tgt = `MSD_TGT_RAM;
      data_idx = ram_row(`MSD_RAM_BLK1_BASE, {1'b0, req_addr[7:0]});
      data_rsvd = 1'b0;
    end else if (hit_sa_data) begin
      data_tgt = `MSD_TGT_RAM;
      data_idx = ram_row(`MSD_RAM_SA_BASE, req_addr[8:0]);
      data_rsvd = 1'b0;
    end else if (hit_devid) begin
      data_tgt = `MSD_TGT_DEVID;
      data_rsvd = 1'b0;
    end else if (hit_periph) begin
      data_tgt = `MSD_TGT_PERIPH;
      data_rsvd = 1'b0;
    end
  end

  // Space select; password words pass through but are flagged
  reg [2:0] tgt_next;
  reg [10:0] ram_idx;
  reg rsvd_next;
  reg pwd_next;
  always @* begin
    tgt_next = data_tgt;
    ram_idx = data_idx;
    rsvd_next = data_rsvd;
    pwd_next = 1'b0;
    if (req_prog) begin
      tgt_next = prog_tgt;
      ram_idx = prog_idx;
      rsvd_next = prog_rsvd;
      pwd_next = hit_pwd;
    end
  end

  // Identification word is read-only: writes never reach storage
  wire ram_we = req_valid && req_write && (tgt_next == `MSD_TGT_RAM);
  wire [15:0] ram_q;
  msd_ram #(.AW(11), .DW(16), .DEPTH(1536)) u_ram (
    .clk_sys(clk_sys),
    .wr_en(ram_we),
    .addr(ram_idx),
    .wr_data(req_wdata),
    .rd_data(ram_q)
  );

  // Registered request tracking and off-block steering
  reg rd_pend_reg;
  reg [2:0] rd_tgt_reg;
  always @(posedge clk_sys) begin
    if (reset) begin
      rd_pend_reg <= 1'b0;
      rd_tgt_reg <= `MSD_TGT_NONE;
      tgt_sel <= `MSD_TGT_NONE;
      ext_addr <= 16'h0000;
      ext_write <= 1'b0;
      ext_wdata <= 16'h0000;
      reserved_hit <= 1'b0;
      password_hit <= 1'b0;
    end else begin
      rd_pend_reg <= req_valid && !req_write;
      rd_tgt_reg <= tgt_next;
      tgt_sel <= req_valid ? tgt_next : `MSD_TGT_NONE;
      ext_addr <= req_addr;
      ext_write <= req_valid && req_write && (tgt_next == `MSD_TGT_PERIPH || tgt_next == `MSD_TGT_PSTORE);
      ext_wdata <= req_wdata;
      reserved_hit <= req_valid && rsvd_next;
      password_hit <= req_valid && pwd_next;
    end
  end

  // Read return mux, two cycles after request
  always @(posedge clk_sys) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= rd_pend_reg;
      case (rd_tgt_reg)
        `MSD_TGT_RAM: rd_data <= ram_q;
        `MSD_TGT_DEVID: rd_data <= DEVICE_ID;
        `MSD_TGT_BOOT: rd_data <= BOOT_WORD;
        default: rd_data <= 16'h0000;
      endcase
    end
  end
endmodule // msd_decode
`default_nettype wire

// ### msd_decode_test.sv
// Purpose: directed scenarios for the space decoder
// Assumes: read answer exactly two cycles after the request
// Notes: mode bits settle three cycles before use
`timescale 1ns/1ps
`default_nettype none
module msd_decode_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] mode = 4'h0; // bre, pse, dse, bzp
  logic req_valid, req_prog, req_write, rd_valid, ext_write, reserved_hit, password_hit;
  logic [15:0] req_addr, req_wdata, rd_data, ext_addr, ext_wdata;
  logic [2:0] tgt_sel;
  int error_cnt = 0;
  int check_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  msd_cpu_model i_cpu (.clk_sys(clk_sys), .req_valid(req_valid), .req_prog(req_prog), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata));
  msd_decode #(.DEVICE_ID(16'h3c96)) i_dut (.clk_sys(clk_sys), .reset(reset), .block_zero_placement(mode[0]),
    .data_space_sram_enable(mode[1]), .program_space_sram_enable(mode[2]), .boot_rom_enable(mode[3]),
    .req_valid(req_valid), .req_prog(req_prog), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rd_valid(rd_valid), .rd_data(rd_data), .tgt_sel(tgt_sel), .ext_addr(ext_addr), .ext_write(ext_write),
    .ext_wdata(ext_wdata), .reserved_hit(reserved_hit), .password_hit(password_hit));
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read: target and flags after one cycle, data after two
  task rd(input logic p, input logic [15:0] a, input logic [2:0] t, input logic [1:0] f, input logic [15:0] d);
    i_cpu.bus(p, 1'b0, a, 16'h0);
    chk({11'h0, reserved_hit, password_hit, tgt_sel}, {11'h0, f, t});
    @(posedge clk_sys);
    #1 chk({15'h0, rd_valid}, 16'h1);
    chk(rd_data, d);
  endtask
  task setm(input logic [3:0] m);
    mode = m;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task t_blk1;
    i_cpu.bus(1'b0, 1'b1, 16'h0400, 16'h1234);
    rd(1'b0, 16'h0300, 3'h3, 2'b00, 16'h1234);
    i_cpu.bus(1'b0, 1'b1, 16'h03ff, 16'ha5a5);
    rd(1'b0, 16'h04ff, 3'h3, 2'b00, 16'ha5a5);
  endtask
  task t_blk0;
    i_cpu.bus(1'b0, 1'b1, 16'h0105, 16'h0b0b);
    rd(1'b0, 16'h0205, 3'h3, 2'b00, 16'h0b0b);
    setm(4'h1);
    rd(1'b0, 16'h0205, 3'h0, 2'b10, 16'h0);
    i_cpu.bus(1'b1, 1'b1, 16'hfe07, 16'h7e07);
    rd(1'b1, 16'hff07, 3'h3, 2'b00, 16'h7e07);
  endtask
  task t_boot;
    setm(4'h8);
    rd(1'b1, 16'h0010, 3'h1, 2'b00, 16'h0);
    setm(4'h0);
    rd(1'b1, 16'h0041, 3'h2, 2'b01, 16'h0);
    rd(1'b1, 16'h0044, 3'h2, 2'b00, 16'h0);
  endtask
  task t_id;
    rd(1'b0, 16'h701c, 3'h4, 2'b00, 16'h3c96);
    i_cpu.bus(1'b0, 1'b1, 16'h701c, 16'hffff);
    chk({15'h0, ext_write}, 16'h0);
    chk(ext_addr, 16'h701c);
    i_cpu.bus(1'b0, 1'b1, 16'h7000, 16'hbeef);
    chk({15'h0, ext_write}, 16'h1);
    chk(ext_wdata, 16'hbeef);
    rd(1'b0, 16'h701c, 3'h4, 2'b00, 16'h3c96);
  endtask
  task t_sa;
    rd(1'b0, 16'h0800, 3'h0, 2'b10, 16'h0);
    setm(4'h2);
    i_cpu.bus(1'b0, 1'b1, 16'h09ff, 16'h5e5e);
    rd(1'b0, 16'h09ff, 3'h3, 2'b00, 16'h5e5e);
    rd(1'b1, 16'h8000, 3'h0, 2'b10, 16'h0);
    setm(4'h4);
    i_cpu.bus(1'b1, 1'b1, 16'h81ff, 16'h6f6f);
    rd(1'b1, 16'h81ff, 3'h3, 2'b00, 16'h6f6f);
  endtask
  task report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_blk1;
    t_blk0;
    t_boot;
    t_id;
    t_sa;
    report_and_stop;
  end
endmodule // msd_decode_test
`default_nettype wire

// ### msd_ram.v
// Purpose: on-chip RAM shared by blocks zero, one, two and single-access RAM
// Assumes: one access per cycle, registered read data
// Notes: one physical word per location, so every alias hits the same cell
`timescale 1ns/1ps
`default_nettype none
module msd_ram #(
  parameter AW = 11,
  parameter DW = 16,
  parameter DEPTH = 1536
) (
  input wire clk_sys,
  input wire wr_en,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wr_data,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // Read before write, data leaves a register
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // msd_ram
`default_nettype wire

// ### msd_regs.vh
// Purpose: constants for the memory space decoder
// Assumes: 16-bit word addresses on program and data buses
// Notes: address windows, target codes and RAM row bases listed below
`ifndef MSD_REGS_VH
`define MSD_REGS_VH
`define MSD_BLK0_PROG_ALIAS 16'hfe00
`define MSD_BLK0_PROG_BASE 16'hff00
`define MSD_BLK0_DATA_ALIAS 16'h0100
`define MSD_BLK0_DATA_BASE 16'h0200
`define MSD_BLK0_DATA_LAST 16'h02ff
`define MSD_BLK1_DATA_BASE 16'h0300
`define MSD_BLK1_DATA_ALIAS 16'h0400
`define MSD_BLK1_DATA_LAST 16'h04ff
`define MSD_B2_DATA_BASE 16'h0060
`define MSD_B2_DATA_LAST 16'h007f
`define MSD_BOOT_LAST 16'h00ff
`define MSD_PWD_FIRST 16'h0040
`define MSD_PWD_LAST 16'h0043
`define MSD_USER_START 16'h0044
`define MSD_PSTORE_LAST 16'h1fff
`define MSD_SA_DATA_BASE 16'h0800
`define MSD_SA_DATA_LAST 16'h09ff
`define MSD_SA_PROG_BASE 16'h8000
`define MSD_SA_PROG_LAST 16'h81ff
`define MSD_DEVID_ADDR 16'h701c
`define MSD_PERIPH_BASE 16'h7000
`define MSD_PERIPH_LAST 16'h7fff
`define MSD_TGT_NONE 3'h0
`define MSD_TGT_BOOT 3'h1
`define MSD_TGT_PSTORE 3'h2
`define MSD_TGT_RAM 3'h3
`define MSD_TGT_DEVID 3'h4
`define MSD_TGT_PERIPH 3'h5
`define MSD_RAM_BLK0_BASE 11'h000
`define MSD_RAM_BLK1_BASE 11'h100
`define MSD_RAM_B2_BASE 11'h200
`define MSD_RAM_SA_BASE 11'h400
`endif
